// ==== core/urd_pkg.sv ====
package urd_pkg;
  localparam logic [2:0] ADR_HOLD = 3'h0;
  localparam logic [2:0] ADR_IEN = 3'h1;
  localparam logic [2:0] ADR_B2 = 3'h2;
  localparam logic [2:0] ADR_FMT = 3'h3;
  localparam logic [2:0] ADR_B4 = 3'h4;
  localparam logic [2:0] ADR_B5 = 3'h5;
  localparam logic [2:0] ADR_B6 = 3'h6;
  localparam logic [2:0] ADR_B7 = 3'h7;
  localparam logic [7:0] UNLOCK_VALUE = 8'hBF;
  localparam int DLAB_BIT = 7;
  localparam int FILL_SEL_BIT = 0;
  localparam logic [1:0] XBANK_LEVELS = 2'h1;
  localparam logic [1:0] XBANK_EXTRA = 2'h2;
  localparam int QEN_BIT = 0;
  localparam int TXTRIG_EN_BIT = 4;
  localparam int AUTO_RTS_BIT = 6;
  localparam int AUTO_CTS_BIT = 7;
  localparam int PAR_EN_BIT = 3;
  localparam int PAR_EVEN_BIT = 4;
  localparam int STOP2_BIT = 2;
  localparam logic [7:0] RESET_DIVISOR_LOW = 8'h01;
  localparam int COMPAT_DEPTH = 32;
  localparam int EXT_DEPTH = 128;
  localparam int TIMEOUT_CHARS = 4;
  localparam int BITS_PER_CHAR_MAX = 12;
  localparam logic [7:0] ZERO8 = 8'h00;
endpackage : urd_pkg

// ==== core/urd_uart.sv ====
// How it works
// - Extended mode whenever any of the four level registers is nonzero.
// - Line format bit 7 clear selects the general bank at offsets 0 to 7.
// - Line format bit 7 set maps divisor low and high at offsets 0, 1.
// - Extra control bit 0 exposes read-only fill counts at offsets 3 and 4.
// - Unlock value opens enhanced feature and the four flow characters.
// - Extra control code 01 opens the four level registers.
// - Extra control code 10 opens prescale, turnaround and extra features.
// - All four levels zero gives 32-entry queues.
// - Compatible triggers follow queue control bits 7:6 and 5:4 tables.
// - Compatible halt and resume thresholds follow queue control bits 7:6.
// - Queue control bit 0 enables the transmit queue depth; the receive queue ignores it.
// - Transmit trigger from queue control waits for enhanced feature bit 4.
// - Receive time-out signals any data left sitting in the receive queue.
// - Extended triggers equal the two interrupt level registers.
// - Queue enable toggle or mode change flushes both queues.
// - Sleep only when receive idle, transmitter empty, no receive interrupt.
// - Characters framed with start, stop, optional parity; parity checked.
// - Baud divisor is sixteen bits, one to 65535.
// - Status registers readable except under the unlock value or, at offsets 2 and 6, a level or extra bank.
// - Reset leaves legacy behaviour with extended features off.
// - Hardware flow by request and clear to send, software by characters.
// - Enhanced bits 6, 7 enable auto request/clear; stop after stop bit.
// - Extended flow halts at high count and resumes at low count.
module urd_uart
  import urd_pkg::*;
#(
  parameter int DEPTH = EXT_DEPTH
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [2:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic rx_pin,
  input wire logic cts_n_pin,
  output logic tx_pin,
  output logic rts_n_pin,
  output logic rx_interrupt,
  output logic tx_interrupt,
  output logic sleep_ok
);
  localparam int CW = $clog2(DEPTH + 1);
  typedef enum logic [1:0] {URD_IDLE, URD_START, URD_DATA, URD_STOP} urd_e;

  logic [7:0] line_format, int_enable, queue_control, scratchpad;
  logic [7:0] divisor_low, divisor_high, extra_feature_control;
  logic [7:0] enhanced_feature, modem_control;
  logic [7:0] resume_char_first, resume_char_second;
  logic [7:0] halt_char_first, halt_char_second;
  logic [7:0] tx_queue_int_level, rx_queue_int_level;
  logic [7:0] flow_count_high, flow_count_low;
  logic [7:0] clock_prescale, driver_turnaround_timer;
  logic [7:0] extra_feature_two, extra_feature_one;
  logic [7:0] txq [DEPTH];
  logic [7:0] rxq [DEPTH];
  logic [CW-1:0] tx_cnt, rx_cnt;
  logic [CW-2:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic ext_mode, ext_mode_q, qen_q, flush;
  logic gen_bank, unlock, fill_bank, lvl_bank, xtra_bank;
  logic [CW-1:0] depth_now, rx_trig, tx_trig, halt_th, resume_th;
  logic tx_push, tx_pop, rx_push, rx_pop;
  logic rx_s1, rx_s2, cts_s1, cts_s2, halted;
  logic [15:0] baud_cnt;
  logic tick;
  logic parity_err, timeout_flag;
  logic [15:0] idle_ticks;

  assign ext_mode = |{tx_queue_int_level, rx_queue_int_level,
                      flow_count_high, flow_count_low};
  assign depth_now = ext_mode ? CW'(DEPTH) : CW'(COMPAT_DEPTH);
  assign gen_bank = !line_format[DLAB_BIT];
  assign unlock = line_format == UNLOCK_VALUE;
  assign fill_bank = extra_feature_control[FILL_SEL_BIT];
  assign lvl_bank = extra_feature_control[2:1] == XBANK_LEVELS;
  assign xtra_bank = extra_feature_control[2:1] == XBANK_EXTRA;

  always_comb begin
    case (queue_control[7:6])
      2'h0: begin rx_trig = CW'(8); halt_th = CW'(8); resume_th = CW'(0); end
      2'h1: begin rx_trig = CW'(16); halt_th = CW'(16); resume_th = CW'(7); end
      2'h2: begin rx_trig = CW'(24); halt_th = CW'(24); resume_th = CW'(15); end
      default: begin
        rx_trig = CW'(28);
        halt_th = CW'(28);
        resume_th = CW'(23);
      end
    endcase
    case (enhanced_feature[TXTRIG_EN_BIT] ? queue_control[5:4] : 2'h0)
      2'h1: tx_trig = CW'(8);
      2'h2: tx_trig = CW'(24);
      2'h3: tx_trig = CW'(30);
      default: tx_trig = CW'(16);
    endcase
    if (ext_mode) begin
      rx_trig = CW'(rx_queue_int_level);
      tx_trig = CW'(tx_queue_int_level);
      halt_th = CW'(flow_count_high);
      resume_th = CW'(flow_count_low);
    end
  end

  // Register writes; the unlock bank outranks the extra banks.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      line_format <= ZERO8; int_enable <= ZERO8; queue_control <= ZERO8;
      scratchpad <= ZERO8; divisor_low <= RESET_DIVISOR_LOW;
      divisor_high <= ZERO8; extra_feature_control <= ZERO8;
      enhanced_feature <= ZERO8; modem_control <= ZERO8;
      resume_char_first <= ZERO8; resume_char_second <= ZERO8;
      halt_char_first <= ZERO8; halt_char_second <= ZERO8;
      tx_queue_int_level <= ZERO8; rx_queue_int_level <= ZERO8;
      flow_count_high <= ZERO8; flow_count_low <= ZERO8;
      clock_prescale <= ZERO8; driver_turnaround_timer <= ZERO8;
      extra_feature_two <= ZERO8; extra_feature_one <= ZERO8;
    end else if (reg_write) begin
      if (reg_addr == ADR_FMT) line_format <= reg_wdata;
      else if (unlock && reg_addr != ADR_IEN && reg_addr != ADR_HOLD) begin
        case (reg_addr)
          ADR_B2: enhanced_feature <= reg_wdata;
          ADR_B4: resume_char_first <= reg_wdata;
          ADR_B5: resume_char_second <= reg_wdata;
          ADR_B6: halt_char_first <= reg_wdata;
          default: halt_char_second <= reg_wdata;
        endcase
      end else if (!gen_bank && reg_addr == ADR_HOLD) begin
        divisor_low <= reg_wdata;
      end else if (!gen_bank && reg_addr == ADR_IEN) begin
        divisor_high <= reg_wdata;
      end else if (lvl_bank && (reg_addr == ADR_B2 || reg_addr == ADR_B4
                   || reg_addr == ADR_B6 || reg_addr == ADR_B7)) begin
        case (reg_addr)
          ADR_B2: tx_queue_int_level <= reg_wdata;
          ADR_B4: rx_queue_int_level <= reg_wdata;
          ADR_B6: flow_count_high <= reg_wdata;
          default: flow_count_low <= reg_wdata;
        endcase
      end else if (xtra_bank && (reg_addr == ADR_B2 || reg_addr == ADR_B4
                   || reg_addr == ADR_B6 || reg_addr == ADR_B7)) begin
        case (reg_addr)
          ADR_B2: clock_prescale <= reg_wdata;
          ADR_B4: driver_turnaround_timer <= reg_wdata;
          ADR_B6: extra_feature_two <= reg_wdata;
          default: extra_feature_one <= reg_wdata;
        endcase
      end else if (gen_bank) begin
        case (reg_addr)
          ADR_IEN: int_enable <= reg_wdata;
          ADR_B2: queue_control <= reg_wdata;
          ADR_B4: modem_control <= reg_wdata;
          ADR_B5: extra_feature_control <= reg_wdata;
          ADR_B7: scratchpad <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // Read mux mirrors the write decode; status reads never wait.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) reg_rdata <= ZERO8;
    else if (reg_read) begin
      reg_rdata <= ZERO8;
      if (reg_addr == ADR_FMT && !fill_bank) reg_rdata <= line_format;
      else if (unlock && reg_addr != ADR_IEN && reg_addr != ADR_HOLD) begin
        case (reg_addr)
          ADR_B2: reg_rdata <= enhanced_feature;
          ADR_B4: reg_rdata <= resume_char_first;
          ADR_B5: reg_rdata <= resume_char_second;
          ADR_B6: reg_rdata <= halt_char_first;
          default: reg_rdata <= halt_char_second;
        endcase
      end else if (!gen_bank && reg_addr == ADR_HOLD) reg_rdata <= divisor_low;
      else if (!gen_bank && reg_addr == ADR_IEN) reg_rdata <= divisor_high;
      else if (fill_bank && reg_addr == ADR_FMT)
        reg_rdata <= 8'(tx_cnt);
      else if (fill_bank && reg_addr == ADR_B4)
        reg_rdata <= 8'(rx_cnt);
      else if (lvl_bank && reg_addr == ADR_B2) reg_rdata <= tx_queue_int_level;
      else if (lvl_bank && reg_addr == ADR_B4) reg_rdata <= rx_queue_int_level;
      else if (lvl_bank && reg_addr == ADR_B6) reg_rdata <= flow_count_high;
      else if (lvl_bank && reg_addr == ADR_B7) reg_rdata <= flow_count_low;
      else if (xtra_bank && reg_addr == ADR_B2) reg_rdata <= clock_prescale;
      else if (xtra_bank && reg_addr == ADR_B4)
        reg_rdata <= driver_turnaround_timer;
      else if (xtra_bank && reg_addr == ADR_B6) reg_rdata <= extra_feature_two;
      else if (xtra_bank && reg_addr == ADR_B7) reg_rdata <= extra_feature_one;
      else begin
        case (reg_addr)
          ADR_HOLD: reg_rdata <= rxq[rx_rp];
          ADR_IEN: reg_rdata <= int_enable;
          ADR_B2: reg_rdata <= {6'h00, timeout_flag, !rx_interrupt};
          ADR_B4: reg_rdata <= modem_control;
          ADR_B5: reg_rdata <= {1'h0, tx_cnt == '0, tx_cnt == '0,
                                2'h0, parity_err, 1'h0, rx_cnt != '0};
          ADR_B6: reg_rdata <= {3'h0, !cts_s2, 4'h0};
          default: reg_rdata <= scratchpad;
        endcase
      end
    end
  end

  // flush on enable toggle or mode swap.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ext_mode_q <= 1'b0;
      qen_q <= 1'b0;
    end else begin
      ext_mode_q <= ext_mode;
      qen_q <= queue_control[QEN_BIT];
    end
  end
  assign flush = (ext_mode_q != ext_mode) || (qen_q != queue_control[QEN_BIT]);

  // transmit queue fills to depth only while enabled, one entry otherwise; receive queue always fills to depth.
  assign tx_push = reg_write && gen_bank && !unlock && reg_addr == ADR_HOLD
                   && tx_cnt < (queue_control[QEN_BIT] ? depth_now : CW'(1));
  assign rx_pop = reg_read && gen_bank && !unlock && !fill_bank
                  && reg_addr == ADR_HOLD && rx_cnt != '0;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_wp <= '0; tx_rp <= '0; tx_cnt <= '0;
      rx_wp <= '0; rx_rp <= '0; rx_cnt <= '0;
    end else if (flush) begin
      tx_wp <= '0; tx_rp <= '0; tx_cnt <= '0;
      rx_wp <= '0; rx_rp <= '0; rx_cnt <= '0;
    end else begin
      if (tx_push) tx_wp <= tx_wp + 1'b1;
      if (tx_pop) tx_rp <= tx_rp + 1'b1;
      tx_cnt <= tx_cnt + CW'(tx_push) - CW'(tx_pop);
      if (rx_push) rx_wp <= rx_wp + 1'b1;
      if (rx_pop) rx_rp <= rx_rp + 1'b1;
      rx_cnt <= rx_cnt + CW'(rx_push) - CW'(rx_pop);
    end
  end
  always_ff @(posedge clock) begin
    if (tx_push) txq[tx_wp] <= reg_wdata;
  end

  // Pins pass two flops before use.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_s1 <= 1'b1; rx_s2 <= 1'b1; cts_s1 <= 1'b1; cts_s2 <= 1'b1;
    end else begin
      rx_s1 <= rx_pin; rx_s2 <= rx_s1; cts_s1 <= cts_n_pin; cts_s2 <= cts_s1;
    end
  end

  // a zero divisor behaves as one.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      baud_cnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= baud_cnt <= 16'h0001;
      baud_cnt <= (baud_cnt <= 16'h0001) ? {divisor_high, divisor_low}
                                         : baud_cnt - 16'h0001;
    end
  end

  // Transmitter works at bit rate; ticks are one bit time each.
  urd_e tx_state, rx_state;
  logic [10:0] tx_shift;
  logic [3:0] tx_bits, rx_bits;
  logic [7:0] rx_data;
  logic rx_par;
  assign tx_pop = tick && tx_state == URD_IDLE && tx_cnt != '0 && !halted;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      tx_state <= URD_IDLE; tx_shift <= '1; tx_bits <= '0; tx_pin <= 1'b1;
    end else if (tick) begin
      case (tx_state)
        URD_IDLE: if (tx_pop) begin
          tx_shift <= {2'h3, line_format[PAR_EN_BIT] ?
                       (^txq[tx_rp] ^ !line_format[PAR_EVEN_BIT]) : 1'b1,
                       txq[tx_rp]};
          tx_pin <= 1'b0;
          tx_bits <= line_format[PAR_EN_BIT] ? 4'h9 : 4'h8;
          tx_state <= URD_DATA;
        end
        URD_DATA: begin
          tx_pin <= tx_shift[0];
          tx_shift <= {1'b1, tx_shift[10:1]};
          tx_bits <= tx_bits - 4'h1;
          if (tx_bits == 4'h1) tx_state <= URD_STOP;
        end
        URD_STOP: begin
          tx_pin <= 1'b1; // halting is sampled only back in idle.
          tx_state <= URD_IDLE;
        end
        default: tx_state <= URD_IDLE;
      endcase
    end
  end

  // Receiver samples the line once per tick, with no half-bit offset.
  assign rx_push = tick && rx_state == URD_STOP && rx_cnt < depth_now;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_state <= URD_IDLE; rx_bits <= '0; rx_data <= ZERO8;
      rx_par <= 1'b0; parity_err <= 1'b0;
    end else if (tick) begin
      case (rx_state)
        URD_IDLE: if (!rx_s2) begin
          // The start bit was seen at this tick, so the next tick is bit 0.
          rx_state <= URD_DATA;
          rx_bits <= line_format[PAR_EN_BIT] ? 4'h9 : 4'h8;
        end
        URD_START: begin
          rx_state <= rx_s2 ? URD_IDLE : URD_DATA;
          rx_bits <= line_format[PAR_EN_BIT] ? 4'h9 : 4'h8;
        end
        URD_DATA: begin
          if (rx_bits == 4'h1 && line_format[PAR_EN_BIT]) rx_par <= rx_s2;
          else rx_data <= {rx_s2, rx_data[7:1]};
          rx_bits <= rx_bits - 4'h1;
          if (rx_bits == 4'h1) rx_state <= URD_STOP;
        end
        URD_STOP: begin
          parity_err <= line_format[PAR_EN_BIT] &&
            (^rx_data ^ rx_par ^ !line_format[PAR_EVEN_BIT]);
          rx_state <= URD_IDLE;
        end
        default: rx_state <= URD_IDLE;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (rx_push) rxq[rx_wp] <= rx_data;
  end

  // about four character times of quiet with any data in the receive queue.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) idle_ticks <= '0;
    else if (rx_push || rx_pop || rx_cnt == '0) idle_ticks <= '0;
    else if (tick && !timeout_flag) idle_ticks <= idle_ticks + 16'h0001;
  end
  assign timeout_flag = idle_ticks >= 16'(TIMEOUT_CHARS * BITS_PER_CHAR_MAX);

  // flow state; software flow halts on the halt character.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      halted <= 1'b0;
      rts_n_pin <= 1'b1;
    end else begin
      halted <= (enhanced_feature[AUTO_CTS_BIT] && cts_s2)
                || (|enhanced_feature[3:0] && (rx_push
                    ? rx_data == halt_char_first
                      || (halted && rx_data != resume_char_first)
                    : halted && !rx_push));
      if (!enhanced_feature[AUTO_RTS_BIT]) rts_n_pin <= !modem_control[1];
      else if (rx_cnt >= halt_th) rts_n_pin <= 1'b1;
      else if (rx_cnt <= resume_th) rts_n_pin <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_interrupt <= 1'b0; tx_interrupt <= 1'b0; sleep_ok <= 1'b0;
    end else begin
      rx_interrupt <= int_enable[0] && (rx_cnt >= rx_trig || timeout_flag);
      tx_interrupt <= int_enable[1] && tx_cnt <= (depth_now - tx_trig);
      sleep_ok <= rx_state == URD_IDLE && rx_s2 && tx_cnt == '0
                  && tx_state == URD_IDLE && !rx_interrupt;
    end
  end

  sleep_gate_a: assert property (@(posedge clock) disable iff (reset)
    sleep_ok |-> $past(tx_cnt) == '0) else $error("sleep with data");
  flush_empty_a: assert property (@(posedge clock) disable iff (reset)
    flush |=> tx_cnt == '0 && rx_cnt == '0) else $error("flush kept data");
  mode_depth_a: assert property (@(posedge clock) disable iff (reset)
    !ext_mode |-> depth_now == CW'(COMPAT_DEPTH)) else $error("depth");
  ignore_w_a: assert property (@(posedge clock) disable iff (reset)
    reg_write && gen_bank && !lvl_bank && !xtra_bank && reg_addr == ADR_B6
    |=> $stable(scratchpad) && $stable(modem_control))
    else $error("write changed state");
  rx_bound_a: assert property (@(posedge clock) disable iff (reset)
    rx_cnt <= depth_now || flush) else $error("rx over depth");
  unlock_write_a: assert property (@(posedge clock) disable iff (reset)
    reg_write && unlock && reg_addr == ADR_B2
    |=> enhanced_feature == $past(reg_wdata))
    else $error("enhanced feature write lost");
endmodule : urd_uart

// ==== tb/urd_line_peer.sv ====
// Remote serial station facing the block across the line. It sends whole
// frames and captures the ten bits after each start bit, one bit per BIT_CYCLES clocks.
module urd_line_peer #(
  parameter int BIT_CYCLES = 8
) (
  input wire logic clock,
  input wire logic tx_pin,
  output logic rx_pin,
  output logic cts_n_pin
);
  timeunit 1ns;
  timeprecision 100ps;

  // The line rests at the mark level between frames, as a real one does.
  initial begin
    rx_pin = 1'b1;
    cts_n_pin = 1'b0;
  end

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      rx_pin <= frame[i];
      repeat (BIT_CYCLES - 1) @(posedge clock);
    end
  endtask : send_byte

  // Samples mid-bit so that the edge race on tx_pin cannot matter.
  task automatic recv_frame(output logic [9:0] bits);
    int n;
    n = 0;
    bits = 10'h000;
    while (tx_pin !== 1'b0 && n < 4000) begin
      @(posedge clock);
      n++;
    end
    repeat (BIT_CYCLES / 2) @(posedge clock);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT_CYCLES) @(posedge clock);
      bits[i] = tx_pin;
    end
  endtask : recv_frame
endmodule : urd_line_peer

// ==== tb/uart_register_decode_fifo_modes_tb_top.sv ====
module uart_register_decode_fifo_modes_tb_top;
  import urd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic clock;
  logic reset;
  logic [2:0] reg_addr;
  logic reg_write;
  logic reg_read;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic rx_pin;
  logic cts_n_pin;
  logic tx_pin;
  logic rts_n_pin;
  logic rx_interrupt;
  logic tx_interrupt;
  logic sleep_ok;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  urd_uart DUT (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .rx_pin(rx_pin), .cts_n_pin(cts_n_pin),
    .tx_pin(tx_pin), .rts_n_pin(rts_n_pin), .rx_interrupt(rx_interrupt),
    .tx_interrupt(tx_interrupt), .sleep_ok(sleep_ok));

  // Bit period must match the divisor written below.
  urd_line_peer #(.BIT_CYCLES(8)) peer (.clock(clock), .tx_pin(tx_pin),
    .rx_pin(rx_pin), .cts_n_pin(cts_n_pin));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic conclude();
    if (num_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      $display("[ERR] %0t run did not finish in time", $time);
      conclude();
    end
  end

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    #1 d = reg_rdata;
  endtask : rd

  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk({2'b00, d}, {2'b00, e});
  endtask : rdc

  // Sends one byte short of the trigger, then the byte that reaches it.
  task automatic trig(input int n);
    for (int i = 1; i < n; i++) peer.send_byte(i[7:0]);
    #1 chk({9'h000, rx_interrupt}, 10'h000);
    peer.send_byte(8'h77);
    repeat (16) @(posedge clock);
    #1 chk({9'h000, rx_interrupt}, 10'h001);
    chk({9'h000, sleep_ok}, 10'h000);
  endtask : trig

  initial begin
    int trg[4] = '{8, 16, 24, 28};
    logic [7:0] m;
    logic [9:0] f;
    int n;
    reset = 1'b1;
    reg_addr = ADR_HOLD;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_wdata = ZERO8;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    #1 chk({tx_pin, rts_n_pin, reg_rdata}, 10'h300);
    chk({7'h00, rx_interrupt, tx_interrupt, sleep_ok} & 10'h006, 10'h000);
    wr(ADR_FMT, 8'h80);
    rdc(ADR_HOLD, RESET_DIVISOR_LOW);
    rdc(ADR_IEN, 8'h00);
    wr(ADR_HOLD, 8'h08);
    wr(ADR_IEN, 8'h00);
    rdc(ADR_HOLD, 8'h08);
    wr(ADR_FMT, 8'h03);
    wr(ADR_B7, 8'h5A);
    wr(ADR_FMT, UNLOCK_VALUE);
    wr(ADR_B2, 8'h10);
    for (int i = 4; i < 8; i++) wr(i[2:0], 8'hC0 + i[7:0]);
    for (int i = 4; i < 8; i++) rdc(i[2:0], 8'hC0 + i[7:0]);
    rdc(ADR_B2, 8'h10);
    wr(ADR_FMT, 8'h03);
    rdc(ADR_B7, 8'h5A);
    rdc(ADR_FMT, 8'h03);
    rd(ADR_B6, m);
    wr(ADR_B6, 8'hFF);
    rdc(ADR_B6, m);
    wr(ADR_B5, 8'h04);
    for (int i = 2; i < 8; i++) begin
      if (i != 3 && i != 5) wr(i[2:0], 8'hD0 + i[7:0]);
    end
    for (int i = 2; i < 8; i++) begin
      if (i != 3 && i != 5) rdc(i[2:0], 8'hD0 + i[7:0]);
    end
    wr(ADR_B5, 8'h00);
    wr(ADR_IEN, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(ADR_B2, 8'h00);
      wr(ADR_B2, {c[1:0], 6'h01});
      trig(trg[c]);
    end
    wr(ADR_B5, 8'h01);
    rdc(ADR_B4, 8'h1C);
    rdc(ADR_FMT, 8'h00);
    wr(ADR_B2, 8'hC0);
    wr(ADR_B2, 8'hC1);
    rdc(ADR_B4, 8'h00);
    wr(ADR_B5, 8'h02);
    wr(ADR_B4, 8'h05);
    wr(ADR_B5, 8'h00);
    trig(5);
    wr(ADR_B5, 8'h02);
    wr(ADR_B4, 8'h00);
    wr(ADR_B5, 8'h01);
    rdc(ADR_B4, 8'h00);
    wr(ADR_B5, 8'h00);
    peer.send_byte(8'h4E);
    peer.send_byte(8'hB1);
    #1 chk({9'h000, rx_interrupt}, 10'h000);
    n = 0;
    while (rx_interrupt !== 1'b1 && n < 600) begin
      @(posedge clock);
      n++;
    end
    #1 chk({9'h000, rx_interrupt}, 10'h001);
    rdc(ADR_HOLD, 8'h4E);
    rdc(ADR_HOLD, 8'hB1);
    wr(ADR_HOLD, 8'hA5);
    peer.recv_frame(f);
    chk(f, {2'b11, 8'hA5});
    wr(ADR_FMT, 8'h1B);
    wr(ADR_HOLD, 8'h31);
    peer.recv_frame(f);
    chk(f, {2'b11, 8'h31});
    wr(ADR_FMT, 8'h03);
    conclude();
  end
endmodule : uart_register_decode_fifo_modes_tb_top
